//--- core/sleep_and_subtract_exec.sv
// Execution of the power-down and subtract instructions.
// Assumes the decoder presents one instruction word per cycle with a
// valid strobe, and the register file returns the addressed byte in
// the same cycle and writes on the edge that ends the cycle.
`timescale 1ns/10ps
module sleep_and_subtract_exec
  import sleep_sub_pkg::*;
#(
  parameter int unsigned WDOG_PRE_W = WDOG_PRE_W_DEF,
  parameter int unsigned WDOG_CNT_W = WDOG_CNT_W_DEF
) (
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  // Instruction stream from the decoder
  input  wire logic               instr_valid,
  input  wire logic [INSTR_W-1:0] instr_word,
  output logic                    instr_ready,
  // Register file side
  output logic      [FADDR_W-1:0] file_addr,
  input  wire logic [DATA_W-1:0]  file_rdata,
  output logic                    file_we,
  output logic      [DATA_W-1:0]  file_wdata,
  // Power and watchdog
  input  wire logic               wake_in,
  output logic                    osc_run,
  output logic                    wdog_expired,
  // Accumulator and status as seen by the rest of the core
  output logic      [DATA_W-1:0]  acc_value,
  output logic      [ST_W-1:0]    status_value,
  // Software register port
  input  wire logic [RADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0]  reg_wdata,
  input  wire logic               reg_write,
  input  wire logic               reg_read,
  output logic      [DATA_W-1:0]  reg_rdata
);

  initial begin
    if (WDOG_PRE_W < 1 || WDOG_CNT_W < 1 || WDOG_CNT_W > DATA_W) begin
      $error("watchdog widths out of range");
    end
  end

  // State registers
  core_state_e             state_q, state_d;
  logic [DATA_W-1:0]       acc_q, acc_d;
  logic [ST_W-1:0]         status_q, status_d;
  logic [WDOG_PRE_W-1:0]   pre_q, pre_d;
  logic [WDOG_CNT_W-1:0]   wdog_q, wdog_d;
  logic                    expired_q, expired_d;
  logic [DATA_W-1:0]       rdata_q, rdata_d;
  logic                    wake_meta_q, wake_sync_q;

  // Decode and arithmetic
  logic                    take_instr;
  logic                    is_power_down;
  logic                    is_subtract;
  logic                    dest_file;
  logic [DATA_W-1:0]       sub_diff;
  logic                    sub_carry;
  logic                    sub_nibble;
  logic                    sub_zero;
  logic                    pre_wrap;
  logic                    wdog_wrap;

  // Wake pin comes from outside the clock domain: two flops first
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wake_meta_q <= 1'b0;
      wake_sync_q <= 1'b0;
    end else begin
      wake_meta_q <= wake_in;
      wake_sync_q <= wake_meta_q;
    end
  end

  // Nothing is taken while halted; the decoder must hold its word
  assign instr_ready   = (state_q == CORE_RUN);
  assign take_instr    = instr_valid && instr_ready;
  assign is_power_down = take_instr && (instr_word == OPC_POWER_DOWN);
  assign is_subtract   = take_instr &&
    (instr_word[INSTR_W-1:OPC_TOP_LSB] == OPC_SUB_TOP);
  assign dest_file     = instr_word[DEST_BIT];             // RULE6

  // File address follows the instruction word combinationally
  assign file_addr = instr_word[FADDR_W-1:0];              // RULE6

  sub_flags #(
    .WIDTH      (DATA_W)
  ) u_sub (
    .minuend    (file_rdata),
    .subtrahend (acc_q),
    .diff       (sub_diff),
    .carry_out  (sub_carry),
    .nibble_out (sub_nibble),
    .zero_out   (sub_zero)
  );

  // Write-back strobe lands on the same edge as the flag update, so
  // the next instruction sees file and flags agree
  assign file_we    = is_subtract && dest_file;            // RULE10
  assign file_wdata = sub_diff;

  // Run/halt control
  always_comb begin
    state_d = state_q;
    case (state_q)
      CORE_RUN: begin
        if (is_power_down) begin
          state_d = CORE_HALT;                             // RULE1
        end
      end
      CORE_HALT: begin
        if (wake_sync_q) begin
          state_d = CORE_RUN;
        end
      end
      default: begin
        state_d = CORE_RUN;
      end
    endcase
  end

  // Watchdog prescaler and counter keep ticking while halted, as a
  // watchdog running from its own source would
  assign pre_wrap  = (pre_q == '1);
  assign wdog_wrap = pre_wrap && (wdog_q == '1);

  always_comb begin
    pre_d     = pre_q + 1'b1;
    wdog_d    = pre_wrap ? wdog_q + 1'b1 : wdog_q;
    expired_d = wdog_wrap;
    if (is_power_down) begin
      pre_d     = '0;                                      // RULE4
      wdog_d    = '0;                                      // RULE4
      expired_d = 1'b0;
    end
  end

  // Accumulator and status: instruction results win over software
  // writes in the same cycle so no hardware update is lost
  always_comb begin
    acc_d    = acc_q;
    status_d = status_q;
    if (reg_write && reg_addr == REG_ACC) begin
      acc_d = reg_wdata;
    end
    if (reg_write && reg_addr == REG_STATUS) begin
      status_d = reg_wdata[ST_W-1:0];
    end
    if (wdog_wrap) begin
      status_d[ST_EXPIRY] = 1'b0;
    end
    if (is_subtract) begin
      if (!dest_file) begin
        acc_d = sub_diff;                                  // RULE6
      end
      status_d[ST_CARRY]  = sub_carry;                     // RULE7
      status_d[ST_NIBBLE] = sub_nibble;                    // RULE9
      status_d[ST_ZERO]   = sub_zero;                      // RULE8
    end
    if (is_power_down) begin
      status_d[ST_PDOWN]  = 1'b0;                          // RULE2
      status_d[ST_EXPIRY] = 1'b1;                          // RULE3
    end
  end

  // Read data appear the cycle after the strobe, zero otherwise
  always_comb begin
    rdata_d = '0;
    if (reg_read) begin
      case (reg_addr)
        REG_ACC: begin
          rdata_d = acc_q;
        end
        REG_STATUS: begin
          rdata_d[ST_W-1:0] = status_q;
        end
        REG_CORE: begin
          rdata_d[CORE_HALTED]  = (state_q == CORE_HALT);
          rdata_d[CORE_OSC_RUN] = (state_q == CORE_RUN);
        end
        REG_WDOG: begin
          rdata_d[WDOG_CNT_W-1:0] = wdog_q;
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  // All state registers except the two wake synchroniser flops
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q   <= CORE_RUN;
      acc_q     <= ACC_RST;
      status_q  <= STATUS_RST;
      pre_q     <= '0;
      wdog_q    <= '0;
      expired_q <= 1'b0;
      rdata_q   <= '0;
    end else begin
      state_q   <= state_d;
      acc_q     <= acc_d;
      status_q  <= status_d;
      pre_q     <= pre_d;
      wdog_q    <= wdog_d;
      expired_q <= expired_d;
      rdata_q   <= rdata_d;
    end
  end

  // Oscillator stops from the edge that commits the power-down
  assign osc_run      = (state_q == CORE_RUN);                 // RULE1
  assign wdog_expired = expired_q;
  assign acc_value    = acc_q;
  assign status_value = status_q;
  assign reg_rdata    = rdata_q;

endmodule

//--- include/sleep_sub_pkg.sv
// Constants for the power-down and subtract execution block.
// Assumes a 14-bit instruction word and an 8-bit data path.
// Notes on behaviour
// RULE1: Power-down opcode halts core, stops oscillator, one cycle.
// RULE2: Power-down clears the power-down flag.
// RULE3: Power-down sets the expiry indicator.
// RULE4: Power-down clears watchdog counter and prescaler first.
// RULE5: Subtract computes file minus accumulator, one cycle.
// RULE6: Destination bit picks accumulator or file register.
// RULE7: Carry is inverted borrow after subtract.
// RULE8: Zero flag set when result is zero.
// RULE9: Nibble flag is inverted low-nibble borrow only.
// RULE10: Result and flags commit together, same edge.
package sleep_sub_pkg;

  localparam int unsigned DATA_W  = 8;
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned RADDR_W = 2;
  localparam int unsigned NIB_W   = 4;

  // Instruction encodings and fields
  localparam logic [INSTR_W-1:0] OPC_POWER_DOWN = 14'h0063;
  localparam logic [5:0]         OPC_SUB_TOP    = 6'h02;
  localparam int unsigned        OPC_TOP_LSB    = 8;
  localparam int unsigned        DEST_BIT       = 7;

  // Register offsets on the plain port
  localparam logic [RADDR_W-1:0] REG_ACC    = 2'h0;
  localparam logic [RADDR_W-1:0] REG_STATUS = 2'h1;
  localparam logic [RADDR_W-1:0] REG_CORE   = 2'h2;
  localparam logic [RADDR_W-1:0] REG_WDOG   = 2'h3;

  // Status register bit positions
  localparam int unsigned ST_CARRY  = 0;
  localparam int unsigned ST_NIBBLE = 1;
  localparam int unsigned ST_ZERO   = 2;
  localparam int unsigned ST_PDOWN  = 3;
  localparam int unsigned ST_EXPIRY = 4;
  localparam int unsigned ST_W      = 5;

  // Core state register bit positions
  localparam int unsigned CORE_HALTED  = 0;
  localparam int unsigned CORE_OSC_RUN = 1;

  // Reset values
  localparam logic [DATA_W-1:0] ACC_RST    = 8'h00;
  localparam logic [ST_W-1:0]   STATUS_RST = 5'h18;

  // Watchdog defaults
  localparam int unsigned WDOG_PRE_W_DEF = 7;
  localparam int unsigned WDOG_CNT_W_DEF = 8;

  typedef enum logic [0:0] {
    CORE_RUN  = 1'b0,
    CORE_HALT = 1'b1
  } core_state_e;

endpackage

//--- core/sub_flags.sv
// Eight-bit subtractor with inverted-borrow flags.
// Assumes purely combinational use inside one instruction cycle.
`timescale 1ns/10ps
module sub_flags
  import sleep_sub_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_W
) (
  input  wire logic [WIDTH-1:0] minuend,
  input  wire logic [WIDTH-1:0] subtrahend,
  output logic      [WIDTH-1:0] diff,
  output logic                  carry_out,
  output logic                  nibble_out,
  output logic                  zero_out
);

  initial begin
    if (WIDTH <= NIB_W) begin
      $error("sub_flags: WIDTH must exceed one nibble");
    end
  end

  logic [WIDTH:0] full_diff;
  logic [NIB_W:0] low_diff;

  // Two's complement: the extra top bit is the borrow out
  always_comb begin
    full_diff  = {1'b0, minuend} - {1'b0, subtrahend};
    low_diff   = {1'b0, minuend[NIB_W-1:0]} -
                 {1'b0, subtrahend[NIB_W-1:0]};
    diff       = full_diff[WIDTH-1:0];          // RULE5
    carry_out  = ~full_diff[WIDTH];             // RULE7
    nibble_out = ~low_diff[NIB_W];              // RULE9
    zero_out   = (full_diff[WIDTH-1:0] == '0);  // RULE8
  end

endmodule

//--- tb/file_model.sv
// Register file model facing the block: 128 bytes, same-cycle read.
// Assumes the block writes only with file_we high at a rising edge.
`timescale 1ns/10ps
module file_model
  import sleep_sub_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic [FADDR_W-1:0] file_addr,
  input  wire logic               file_we,
  input  wire logic [DATA_W-1:0]  file_wdata,
  output logic      [DATA_W-1:0]  file_rdata
);
  logic [DATA_W-1:0] mem [128];
  // Seeded by formula so the bench can predict every byte
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 29 + 3);
  assign file_rdata = mem[file_addr];
  // Write lands on the edge that closes the instruction cycle
  always @(posedge clk_sys) if (file_we) mem[file_addr] <= file_wdata;
endmodule

//--- tb/sleep_and_subtract_exec_properties.sv
// Checker for the power-down and subtract block.
// Assumes only the top-level ports; attached by the bind below.
`timescale 1ns/10ps
module sse_checker
  import sleep_sub_pkg::*;
#(
  parameter int unsigned WDOG_PRE_W = WDOG_PRE_W_DEF,
  parameter int unsigned WDOG_CNT_W = WDOG_CNT_W_DEF
) (
  input wire logic               clk_sys,
  input wire logic               reset_n,
  input wire logic               instr_valid,
  input wire logic [INSTR_W-1:0] instr_word,
  input wire logic               instr_ready,
  input wire logic [DATA_W-1:0]  file_rdata,
  input wire logic               file_we,
  input wire logic [DATA_W-1:0]  file_wdata,
  input wire logic               osc_run,
  input wire logic               wdog_expired,
  input wire logic [DATA_W-1:0]  acc_value,
  input wire logic [ST_W-1:0]    status_value
);
  logic slp, sub, ge, nge, zr;
  logic [DATA_W-1:0] dif;
  // Decoded view of the word taken this cycle
  assign slp = instr_valid && instr_ready && instr_word == OPC_POWER_DOWN;
  assign sub = instr_valid && instr_ready && instr_word[13:8] == OPC_SUB_TOP;
  assign dif = file_rdata - acc_value;
  assign ge  = file_rdata >= acc_value;
  assign nge = file_rdata[3:0] >= acc_value[3:0];
  assign zr  = dif == 8'h00;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_sleep_halts: assert property (slp |=> !osc_run && !instr_ready)
    else $error("core still running after power-down");
  a_sleep_pd: assert property (slp |=> !status_value[ST_PDOWN])
    else $error("power-down flag not cleared");
  a_sleep_expiry: assert property (slp |=> status_value[ST_EXPIRY])
    else $error("expiry indicator not set");
  // Prescaler and counter restart, so no wrap pulse can follow soon
  a_wdog_restart: assert property (slp |-> ##2 (!wdog_expired)[*6])
    else $error("watchdog expired right after power-down");
  a_file_write: assert property (sub && instr_word[DEST_BIT]
    |-> file_we && file_wdata == dif)
    else $error("file write-back wrong");
  a_acc_dest: assert property (sub && !instr_word[DEST_BIT]
    |-> !file_we ##1 acc_value == $past(dif))
    else $error("accumulator result wrong");
  a_carry_flag: assert property (sub |=>
    status_value[ST_CARRY] == $past(ge))
    else $error("carry flag wrong");
  a_nibble_flag: assert property (sub |=>
    status_value[ST_NIBBLE] == $past(nge))
    else $error("nibble flag wrong");
  a_zero_flag: assert property (sub |=>
    status_value[ST_ZERO] == $past(zr))
    else $error("zero flag wrong");
  a_halt_quiet: assert property (!instr_ready |-> !file_we)
    else $error("write while halted");
  c_sleep: cover property (slp ##1 !instr_ready);
  c_sub_file: cover property (sub && instr_word[DEST_BIT]);
  c_sub_acc: cover property (sub && !instr_word[DEST_BIT] && zr);
  c_wake: cover property (!osc_run ##1 osc_run);
endmodule
bind sleep_and_subtract_exec sse_checker #(.WDOG_PRE_W(WDOG_PRE_W),
  .WDOG_CNT_W(WDOG_CNT_W)) u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .instr_valid(instr_valid), .instr_word(instr_word),
  .instr_ready(instr_ready), .file_rdata(file_rdata), .file_we(file_we),
  .file_wdata(file_wdata), .osc_run(osc_run), .wdog_expired(wdog_expired),
  .acc_value(acc_value), .status_value(status_value));

//--- tb/sleep_and_subtract_exec_tb.sv
// Self-checking bench for the power-down and subtract block.
// Assumes file_model as register file; watchdog shortened to 2/2 bits.
`timescale 1ns/10ps
module sleep_and_subtract_exec_tb
  import sleep_sub_pkg::*;
;
  logic clk_sys = 0, reset_n = 0, instr_valid = 0, wake_in = 0;
  logic reg_write = 0, reg_read = 0, file_we, instr_ready, osc_run;
  logic [INSTR_W-1:0] instr_word = '0;
  logic [FADDR_W-1:0] file_addr;
  logic [DATA_W-1:0]  file_rdata, file_wdata, acc_value, reg_rdata, macc;
  logic [DATA_W-1:0]  reg_wdata = '0;
  logic [RADDR_W-1:0] reg_addr = '0;
  logic [ST_W-1:0]    status_value;
  logic [2:0]         mfl;
  logic [31:0]        lf = 32'h000144A4;
  logic [DATA_W-1:0]  bm [128];
  int                 fails, check_count;
  always #2 clk_sys = ~clk_sys;
  sleep_and_subtract_exec #(.WDOG_PRE_W(2), .WDOG_CNT_W(2)) DUT (
    .clk_sys(clk_sys), .reset_n(reset_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready(instr_ready),
    .file_addr(file_addr), .file_rdata(file_rdata), .file_we(file_we),
    .file_wdata(file_wdata), .wake_in(wake_in), .osc_run(osc_run),
    .wdog_expired(), .acc_value(acc_value), .status_value(status_value),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata));
  file_model fm (.clk_sys(clk_sys), .file_addr(file_addr),
    .file_we(file_we), .file_wdata(file_wdata), .file_rdata(file_rdata));
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, g);
    check_count++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", n, e, g);
      fails++;
    end
  endtask
  // Bus cycles: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    if (a == REG_ACC) macc = d;
  endtask
  task automatic rd(input string n, input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 chk(n, e, reg_rdata);
  endtask
  task automatic ins(input logic [INSTR_W-1:0] w);
    @(posedge clk_sys);
    instr_word <= w;
    instr_valid <= 1'b1;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
  endtask
  // Reference subtract: result to file or accumulator, three flags
  task automatic sub(input logic [6:0] a, input logic d);
    logic [7:0] r;
    r = bm[a] - macc;
    mfl = {r == 8'h00, bm[a][3:0] >= macc[3:0], bm[a] >= macc};
    ins({OPC_SUB_TOP, d, a});
    if (d) bm[a] = r;
    else macc = r;
    chk("acc", macc, acc_value);
    chk("flags", {5'h00, mfl}, 8'(status_value[2:0]));
    chk("file", bm[a], fm.mem[a]);
  endtask
  task automatic end_of_test;
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence; long counts kept short by the 2/2 watchdog
  initial begin
    for (int i = 0; i < 128; i++) bm[i] = 8'(i * 29 + 3);
    macc = ACC_RST;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    #1 chk("status", {3'h0, STATUS_RST}, {3'h0, status_value});
    for (int k = 2; k < 5; k++) begin
      wr(REG_ACC, 8'(k));
      sub(7'h00, 1'b0);
    end
    for (int k = 0; k < 40; k++) begin
      lf = nx(lf);
      if (lf[8]) wr(REG_ACC, lf[23:16]);
      sub(lf[6:0], lf[7]);
    end
    // Software status write: power-down flag set, expiry clear
    wr(REG_STATUS, 8'h0A);
    rd("st_rd", REG_STATUS, 8'h0A);
    sub(7'h7F, 1'b1);
    rd("acc_rd", REG_ACC, macc);
    ins(OPC_POWER_DOWN);
    chk("status", {3'h0, 2'b10, mfl}, {3'h0, status_value});
    chk("run", 8'h00, {6'h00, osc_run, instr_ready});
    rd("wdog", REG_WDOG, 8'h00);
    wr(REG_CORE, 8'hFF);
    rd("core", REG_CORE, 8'h01);
    ins({OPC_SUB_TOP, 1'b1, 7'h09});
    chk("file", bm[9], fm.mem[9]);
    // Wake raised on an edge; osc_run looked at 1 ns after each edge
    @(posedge clk_sys);
    wake_in <= 1'b1;
    for (int i = 0; i < 10 && osc_run !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("wake", 8'h01, {7'h00, osc_run});
    if (osc_run === 1'b1) begin
      @(posedge clk_sys);
      wake_in <= 1'b0;
      sub(7'h09, 1'b1);
    end
    end_of_test;
  end
endmodule
